// [crf_pkg.sv]
// package: constants, types and carriers of the programmer register file
//------------------------------------------------------------------
//------------------------------------------------------------------
package crf_pkg;
	// apb map, byte addresses
	localparam logic [7:0] OFS_PC   = 8'h00;
	localparam logic [7:0] OFS_SP   = 8'h04;
	localparam logic [7:0] OFS_IXA  = 8'h08;
	localparam logic [7:0] OFS_IXB  = 8'h0c;
	localparam logic [7:0] OFS_PGRF = 8'h10;
	localparam logic [7:0] OFS_AF   = 8'h14;
	localparam logic [7:0] OFS_CTRL = 8'h18;
	// ctrl field positions
	localparam int CTRL_BANK = 0;
	localparam int CTRL_AFS  = 1;
	localparam int CTRL_IE   = 2;
	localparam int CTRL_IM   = 4;
	// flag bit positions
	localparam int FL_C  = 0;
	localparam int FL_N  = 1;
	localparam int FL_PV = 2;
	localparam int FL_H  = 4;
	localparam int FL_Z  = 6;
	localparam int FL_S  = 7;
	// reset values and codes
	localparam logic [15:0] RST_W16 = 16'h0000;
	localparam logic [7:0]  RST_B8  = 8'h00;
	localparam logic [1:0]  RST_IM  = 2'h0;
	localparam logic [2:0]  CODE_ACC = 3'h7;
	localparam logic [7:0]  OPC_EXAF = 8'h08;
	localparam logic [7:0]  OPC_EXX  = 8'hd9;
	localparam logic [1:0]  OPC_ALU  = 2'h2;

	typedef enum logic [3:0] {
		ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
		ALU_AND = 4'h4, ALU_XOR = 4'h5, ALU_OR  = 4'h6, ALU_CP  = 4'h7,
		ALU_SLA = 4'h8, ALU_SRA = 4'h9, ALU_SRL = 4'ha, ALU_RL  = 4'hb,
		ALU_RR  = 4'hc, ALU_INC = 4'hd, ALU_DEC = 4'he, ALU_BIT = 4'hf
	} crf_alu_op_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1, ST_FADR = 4'h2, ST_RFA = 4'h4, ST_RFB = 4'h8
	} crf_state_t;

	typedef struct packed {
		logic        fetch;
		logic        jump;
		logic [15:0] jump_addr;
		logic        push;
		logic        pop;
		logic        idx_go;
		logic        idx_sel;
		logic [7:0]  disp;
		logic        vec_go;
		logic        ex_af;
		logic        exx;
		logic        reg_we;
		logic [2:0]  reg_sel;
		logic [7:0]  reg_wd;
		logic        pair_we;
		logic [1:0]  pair_sel;
		logic [15:0] pair_wd;
		logic [1:0]  pair_rsel;
		logic        alu_go;
		crf_alu_op_t alu_op;
		logic [7:0]  alu_b;
		logic        bit_set;
		logic        bit_res;
		logic [2:0]  bit_idx;
		logic        ld_r_from_a;
		logic        ld_i_from_a;
		logic        set_ie;
		logic        clr_ie;
		logic        set_im;
		logic [1:0]  im;
	} crf_ctl_t;

	typedef struct packed {
		logic        ex_af;
		logic        exx;
		logic        alu;
		crf_alu_op_t op;
		logic [2:0]  src;
	} crf_dec_t;
endpackage

// [crf_alu.sv]
// file: 8-bit arithmetic unit of the register file
`timescale 1ns/10ps
`default_nettype none
module crf_alu (
	input  wire logic [3:0] op_i,   // operation code
	input  wire logic [7:0] a_i,    // accumulator operand
	input  wire logic [7:0] b_i,    // second operand
	input  wire logic       cin_i,  // carry in
	input  wire logic       bset_i, // set selected bit
	input  wire logic       bres_i, // reset selected bit
	input  wire logic [2:0] bit_i,  // bit index
	output logic      [7:0] res_o,  // result
	output logic      [7:0] flg_o   // flags
);
	logic [8:0] r9;
	logic [7:0] msk;
	logic       sub;

	// result and carry per operation
	always_comb begin
		msk = 8'h01 << bit_i;
		sub = 1'b0;
		r9 = {1'b0, a_i};
		case (op_i)
			4'h0: r9 = {1'b0, a_i} + {1'b0, b_i};
			4'h1: r9 = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
			4'h2, 4'h7: begin
				r9 = {1'b0, a_i} - {1'b0, b_i};
				sub = 1'b1;
			end
			4'h3: begin
				r9 = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
				sub = 1'b1;
			end
			4'h4: r9 = {1'b0, a_i & b_i};
			4'h5: r9 = {1'b0, a_i ^ b_i};
			4'h6: r9 = {1'b0, a_i | b_i};
			4'h8: r9 = {a_i, 1'b0};
			4'h9: r9 = {a_i[0], a_i[7], a_i[7:1]};
			4'ha: r9 = {a_i[0], 1'b0, a_i[7:1]};
			4'hb: r9 = {a_i, cin_i};
			4'hc: r9 = {a_i[0], cin_i, a_i[7:1]};
			4'hd: r9 = {1'b0, a_i} + 9'h001;
			4'he: begin
				r9 = {1'b0, a_i} - 9'h001;
				sub = 1'b1;
			end
			4'hf: r9 = {cin_i, bset_i ? (a_i | msk) : bres_i ? (a_i & ~msk) : (a_i & msk)};
			default: r9 = {1'b0, a_i};
		endcase
	end

	// flag image of the result
	always_comb begin
		res_o = r9[7:0];
		flg_o = 8'h00;
		flg_o[crf_pkg::FL_C] = r9[8];
		flg_o[crf_pkg::FL_N] = sub;
		flg_o[crf_pkg::FL_PV] = ~^r9[7:0];
		flg_o[crf_pkg::FL_H] = a_i[4] ^ b_i[4] ^ r9[4];
		flg_o[crf_pkg::FL_Z] = (r9[7:0] == 8'h00);
		flg_o[crf_pkg::FL_S] = r9[7];
	end
endmodule
`default_nettype wire

// [crf_regmem.sv]
// file: two-bank general register storage with registered reads
`timescale 1ns/10ps
`default_nettype none
module crf_regmem (
	input  wire logic       mclk_i, // clock
	input  wire logic       wea_i,  // write enable a
	input  wire logic [3:0] waa_i,  // write address a
	input  wire logic [7:0] wda_i,  // write data a
	input  wire logic       web_i,  // write enable b
	input  wire logic [3:0] wab_i,  // write address b
	input  wire logic [7:0] wdb_i,  // write data b
	input  wire logic [3:0] ra0_i,  // read address 0
	input  wire logic [3:0] ra1_i,  // read address 1
	output logic      [7:0] rd0_o,  // read data 0
	output logic      [7:0] rd1_o   // read data 1
);
	logic [7:0] mem [0:15];

	// write ports, b wins on a clash
	always_ff @(posedge mclk_i) begin
		if (wea_i) begin
			mem[waa_i] <= wda_i;
		end
		if (web_i) begin
			mem[wab_i] <= wdb_i;
		end
	end

	// registered read ports
	always_ff @(posedge mclk_i) begin
		rd0_o <= mem[ra0_i];
		rd1_o <= mem[ra1_i];
	end
endmodule
`default_nettype wire

// [crf_top.sv]
// file: programmer register file with refresh and apb access
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module crf_top (
	input  wire logic              mclk_i,    // clock
	input  wire logic              reset_i,   // sync reset
	input  wire logic              psel_i,    // apb select
	input  wire logic              penable_i, // apb enable
	input  wire logic              pwrite_i,  // apb write
	input  wire logic [7:0]        paddr_i,   // apb address
	input  wire logic [31:0]       pwdata_i,  // apb write data
	output logic      [31:0]       prdata_o,  // apb read data
	output logic                   pready_o,  // apb ready
	output logic                   pslverr_o, // apb error
	input  wire crf_pkg::crf_ctl_t ctl_i,     // sequencer controls
	input  wire logic [7:0]        data_i,    // opcode or vector byte
	output logic      [15:0]       addr_o,    // address bus
	output logic                   refresh_strobe_o, // refresh cycle
	output logic      [7:0]        opcode_o,  // instruction holder
	output crf_pkg::crf_dec_t      dec_o,     // decoded controls
	output logic      [15:0]       pair_rd_o, // selected pair
	output logic      [7:0]        acc_o,     // active accumulator
	output logic      [7:0]        flags_o,   // active flags
	output logic      [15:0]       pc_o,      // program counter
	output logic      [15:0]       sp_o       // stack pointer
);
	//------------------------------------------------------------------
	// storage
	//------------------------------------------------------------------
	logic [15:0] program_counter_reg;
	logic [15:0] stack_pointer_reg;
	logic [15:0] index_base_first_reg;
	logic [15:0] index_base_second_reg;
	logic [7:0]  page_reg;
	logic [7:0]  refresh_reg;
	logic [7:0]  acc_reg [0:1];
	logic [7:0]  flag_reg [0:1];
	logic        afs_reg;
	logic        bank_reg;
	logic        ie_reg;
	logic [1:0]  im_reg;
	logic [15:0] addr_reg;
	logic        refresh_strobe_reg;
	logic [7:0]  opcode_reg;
	crf_pkg::crf_dec_t  dec_reg;
	crf_pkg::crf_state_t state_reg;
	crf_pkg::crf_state_t state_next;
	logic        pready_reg;
	logic        pslverr_reg;
	logic [31:0] prdata_reg;

	//------------------------------------------------------------------
	// request qualifiers
	//------------------------------------------------------------------
	logic        idle;
	logic        fetch_ok;
	logic        mem_ok;
	logic        exec;
	logic        acc_ph;
	logic        hit;
	logic        apb_wr;
	logic [31:0] rd_val;

	// fetch and data accesses start only when idle
	assign idle     = (state_reg == crf_pkg::ST_IDLE);
	assign fetch_ok = idle & ctl_i.fetch;
	assign mem_ok   = idle & ~ctl_i.fetch;
	assign exec     = (state_reg == crf_pkg::ST_RFB);
	assign acc_ph   = psel_i & penable_i;
	assign apb_wr   = acc_ph & pready_reg & pwrite_i & hit;

	//------------------------------------------------------------------
	// fetch and refresh sequence
	//------------------------------------------------------------------
	// fetch address, then two refresh cycles overlapping decode
	always_comb begin
		case (state_reg)
			crf_pkg::ST_IDLE: state_next = fetch_ok ? crf_pkg::ST_FADR : crf_pkg::ST_IDLE;
			crf_pkg::ST_FADR: state_next = crf_pkg::ST_RFA;
			crf_pkg::ST_RFA:  state_next = crf_pkg::ST_RFB;
			crf_pkg::ST_RFB:  state_next = crf_pkg::ST_IDLE;
			default:          state_next = crf_pkg::ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_reg <= crf_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// address bus and refresh strobe
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			addr_reg <= crf_pkg::RST_W16;
			refresh_strobe_reg <= 1'b0;
		end else begin
			refresh_strobe_reg <= (state_next == crf_pkg::ST_RFA) | (state_next == crf_pkg::ST_RFB);
			if (fetch_ok) begin
				addr_reg <= program_counter_reg;
			end else if (state_reg == crf_pkg::ST_FADR) begin
				addr_reg <= {page_reg, refresh_reg};
			end else if (mem_ok & ctl_i.push) begin
				addr_reg <= stack_pointer_reg - 16'h0001;
			end else if (mem_ok & ctl_i.pop) begin
				addr_reg <= stack_pointer_reg;
			end else if (mem_ok & ctl_i.idx_go) begin
				addr_reg <= (ctl_i.idx_sel ? index_base_second_reg : index_base_first_reg)
					+ {{8{ctl_i.disp[7]}}, ctl_i.disp};
			end else if (mem_ok & ctl_i.vec_go) begin
				addr_reg <= {page_reg, data_i};
			end
		end
	end

	//------------------------------------------------------------------
	// program counter and stack pointer
	//------------------------------------------------------------------
	// jump load overrides the incrementer
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			program_counter_reg <= crf_pkg::RST_W16;
		end else if (apb_wr & (paddr_i == crf_pkg::OFS_PC)) begin
			program_counter_reg <= pwdata_i[15:0];
		end else if (ctl_i.jump) begin
			program_counter_reg <= ctl_i.jump_addr;
		end else if (fetch_ok) begin
			program_counter_reg <= program_counter_reg + 16'h0001;
		end
	end

	// stack pointer moves down on push, up on pop
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			stack_pointer_reg <= crf_pkg::RST_W16;
		end else if (apb_wr & (paddr_i == crf_pkg::OFS_SP)) begin
			stack_pointer_reg <= pwdata_i[15:0];
		end else if (mem_ok & ctl_i.push) begin
			stack_pointer_reg <= stack_pointer_reg - 16'h0001;
		end else if (mem_ok & ctl_i.pop) begin
			stack_pointer_reg <= stack_pointer_reg + 16'h0001;
		end
	end

	// index bases, loaded from software
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			index_base_first_reg  <= crf_pkg::RST_W16;
			index_base_second_reg <= crf_pkg::RST_W16;
		end else begin
			if (apb_wr & (paddr_i == crf_pkg::OFS_IXA)) begin
				index_base_first_reg <= pwdata_i[15:0];
			end
			if (apb_wr & (paddr_i == crf_pkg::OFS_IXB)) begin
				index_base_second_reg <= pwdata_i[15:0];
			end
		end
	end

	//------------------------------------------------------------------
	// page and refresh registers
	//------------------------------------------------------------------
	// low seven bits count fetches, top bit holds
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			page_reg    <= crf_pkg::RST_B8;
			refresh_reg <= crf_pkg::RST_B8;
		end else begin
			if (ctl_i.ld_i_from_a) begin
				page_reg <= acc_reg[afs_reg];
			end
			if (apb_wr & (paddr_i == crf_pkg::OFS_PGRF)) begin
				page_reg    <= pwdata_i[15:8];
				refresh_reg <= pwdata_i[7:0];
			end else if (ctl_i.ld_r_from_a) begin
				refresh_reg <= acc_reg[afs_reg];
			end else if (fetch_ok) begin
				refresh_reg <= {refresh_reg[7], refresh_reg[6:0] + 7'h01};
			end
		end
	end

	// interrupt enable and mode
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ie_reg <= 1'b0;
			im_reg <= crf_pkg::RST_IM;
		end else begin
			if (ctl_i.set_ie) begin
				ie_reg <= 1'b1;
			end else if (ctl_i.clr_ie) begin
				ie_reg <= 1'b0;
			end
			if (ctl_i.set_im) begin
				im_reg <= ctl_i.im;
			end
		end
	end

	//------------------------------------------------------------------
	// instruction holder and decode
	//------------------------------------------------------------------
	// latch opcode on fetch, decode it in the next cycle
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			opcode_reg <= crf_pkg::RST_B8;
			dec_reg    <= '0;
		end else begin
			if (fetch_ok) begin
				opcode_reg <= data_i;
			end
			if (state_reg == crf_pkg::ST_FADR) begin
				dec_reg.ex_af <= (opcode_reg == crf_pkg::OPC_EXAF);
				dec_reg.exx   <= (opcode_reg == crf_pkg::OPC_EXX);
				dec_reg.alu   <= (opcode_reg[7:6] == crf_pkg::OPC_ALU) & (opcode_reg[2:0] != 3'h6);
				dec_reg.op    <= crf_pkg::crf_alu_op_t'({1'b0, opcode_reg[5:3]});
				dec_reg.src   <= opcode_reg[2:0];
			end else if (exec) begin
				dec_reg <= '0;
			end
		end
	end

	//------------------------------------------------------------------
	// general banks
	//------------------------------------------------------------------
	logic       wea;
	logic [3:0] waa;
	logic [7:0] wda;
	logic [3:0] ra0;
	logic [3:0] ra1;
	logic [7:0] rd0;
	logic [7:0] rd1;

	// pair writes use both ports, first register high
	assign wea = ctl_i.pair_we | (ctl_i.reg_we & (ctl_i.reg_sel < 3'h6));
	assign waa = ctl_i.pair_we ? {bank_reg, ctl_i.pair_sel, 1'b0} : {bank_reg, ctl_i.reg_sel};
	assign wda = ctl_i.pair_we ? ctl_i.pair_wd[15:8] : ctl_i.reg_wd;
	// decode steals read port 0 for the operand
	assign ra0 = (state_reg == crf_pkg::ST_RFA) ? {bank_reg, dec_reg.src} : {bank_reg, ctl_i.pair_rsel, 1'b0};
	assign ra1 = {bank_reg, ctl_i.pair_rsel, 1'b1};

	crf_regmem u_mem (
		.mclk_i (mclk_i),
		.wea_i  (wea),
		.waa_i  (waa),
		.wda_i  (wda),
		.web_i  (ctl_i.pair_we),
		.wab_i  ({bank_reg, ctl_i.pair_sel, 1'b1}),
		.wdb_i  (ctl_i.pair_wd[7:0]),
		.ra0_i  (ra0),
		.ra1_i  (ra1),
		.rd0_o  (rd0),
		.rd1_o  (rd1)
	);

	// bank and pair selectors toggle on exchange
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			bank_reg <= 1'b0;
			afs_reg  <= 1'b0;
		end else if (apb_wr & (paddr_i == crf_pkg::OFS_CTRL)) begin
			bank_reg <= pwdata_i[crf_pkg::CTRL_BANK];
			afs_reg  <= pwdata_i[crf_pkg::CTRL_AFS];
		end else begin
			if (ctl_i.exx | (exec & dec_reg.exx)) begin
				bank_reg <= ~bank_reg;
			end
			if (ctl_i.ex_af | (exec & dec_reg.ex_af)) begin
				afs_reg <= ~afs_reg;
			end
		end
	end

	//------------------------------------------------------------------
	// accumulator, flags and arithmetic unit
	//------------------------------------------------------------------
	logic [3:0] aop;
	logic [7:0] bop;
	logic [7:0] ares;
	logic [7:0] aflg;
	logic       ago;

	// decoded operation wins the unit in its execute cycle
	assign ago = exec ? dec_reg.alu : ctl_i.alu_go;
	assign aop = exec ? dec_reg.op : ctl_i.alu_op;
	assign bop = exec ? ((dec_reg.src == crf_pkg::CODE_ACC) ? acc_reg[afs_reg] : rd0) : ctl_i.alu_b;

	crf_alu u_alu (
		.op_i   (aop),
		.a_i    (acc_reg[afs_reg]),
		.b_i    (bop),
		.cin_i  (flag_reg[afs_reg][crf_pkg::FL_C]),
		.bset_i (ctl_i.bit_set & ~exec),
		.bres_i (ctl_i.bit_res & ~exec),
		.bit_i  (ctl_i.bit_idx),
		.res_o  (ares),
		.flg_o  (aflg)
	);

	// results land in the active pair
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			acc_reg[0]  <= crf_pkg::RST_B8;
			acc_reg[1]  <= crf_pkg::RST_B8;
			flag_reg[0] <= crf_pkg::RST_B8;
			flag_reg[1] <= crf_pkg::RST_B8;
		end else if (apb_wr & (paddr_i == crf_pkg::OFS_AF)) begin
			acc_reg[afs_reg]  <= pwdata_i[15:8];
			flag_reg[afs_reg] <= pwdata_i[7:0];
		end else if (ago) begin
			if ((aop != 4'h7) & ((aop != 4'hf) | ctl_i.bit_set | ctl_i.bit_res)) begin
				acc_reg[afs_reg] <= ares;
			end
			flag_reg[afs_reg] <= aflg;
		end else if (ctl_i.reg_we & (ctl_i.reg_sel == crf_pkg::CODE_ACC)) begin
			acc_reg[afs_reg] <= ctl_i.reg_wd;
		end
	end

	//------------------------------------------------------------------
	// apb slave, one wait state
	//------------------------------------------------------------------
	// address decode and read mux
	always_comb begin
		hit = (paddr_i[1:0] == 2'h0) & (paddr_i <= crf_pkg::OFS_CTRL);
		rd_val = 32'h0000_0000;
		case (paddr_i)
			crf_pkg::OFS_PC:   rd_val[15:0] = program_counter_reg;
			crf_pkg::OFS_SP:   rd_val[15:0] = stack_pointer_reg;
			crf_pkg::OFS_IXA:  rd_val[15:0] = index_base_first_reg;
			crf_pkg::OFS_IXB:  rd_val[15:0] = index_base_second_reg;
			crf_pkg::OFS_PGRF: rd_val[15:0] = {page_reg, refresh_reg};
			crf_pkg::OFS_AF:   rd_val[15:0] = {acc_reg[afs_reg], flag_reg[afs_reg]};
			crf_pkg::OFS_CTRL: rd_val[7:0]  = {2'h0, im_reg, 1'b0, ie_reg, afs_reg, bank_reg};
			default:           rd_val = 32'h0000_0000;
		endcase
	end

	// ready rises one cycle into the access phase
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg <= acc_ph & ~pready_reg;
			if (acc_ph & ~pready_reg) begin
				pslverr_reg <= ~hit;
				prdata_reg  <= pwrite_i ? 32'h0000_0000 : rd_val;
			end else begin
				pslverr_reg <= 1'b0;
			end
		end
	end

	//------------------------------------------------------------------
	// outputs
	//------------------------------------------------------------------
	assign prdata_o         = prdata_reg;
	assign pready_o         = pready_reg;
	assign pslverr_o        = pslverr_reg;
	assign addr_o           = addr_reg;
	assign refresh_strobe_o = refresh_strobe_reg;
	assign opcode_o         = opcode_reg;
	assign dec_o            = dec_reg;
	assign pair_rd_o        = {rd0, rd1};
	assign acc_o            = acc_reg[afs_reg];
	assign flags_o          = flag_reg[afs_reg];
	assign pc_o             = program_counter_reg;
	assign sp_o             = stack_pointer_reg;
endmodule
`default_nettype wire

// [crf_seq_model.sv]
// file: behavioural control sequencer that feeds the register file
`timescale 1ns/10ps
`default_nettype none
module crf_seq_model (
	input  wire logic         mclk_i, // clock
	output crf_pkg::crf_ctl_t ctl_o,  // control word
	output logic [7:0]        data_o  // opcode or vector byte
);
	initial begin
		ctl_o = '0;
		data_o = 8'h00;
	end
	// one request for one cycle, then the data line stops showing its value
	task automatic pulse(input crf_pkg::crf_ctl_t c, input logic [7:0] d);
		@(posedge mclk_i);
		ctl_o <= c;
		data_o <= d;
		@(posedge mclk_i);
		ctl_o <= '0;
		data_o <= ~d;
		#1;
	endtask
endmodule
`default_nettype wire

// [crf_properties.sv]
// file: concurrent checks on the register file ports
`timescale 1ns/10ps
`default_nettype none
module crf_properties (
	input wire logic              mclk_i,    // clock
	input wire logic              reset_i,   // sync reset
	input wire logic              psel_i,    // apb select
	input wire logic              penable_i, // apb enable
	input wire logic              pready_o,  // apb ready
	input wire crf_pkg::crf_ctl_t ctl_i,     // controls
	input wire logic [7:0]        data_i,    // data byte
	input wire logic [15:0]       addr_o,    // address bus
	input wire logic              refresh_strobe_o, // refresh
	input wire logic [7:0]        opcode_o,  // opcode
	input wire logic [15:0]       pc_o,      // program counter
	input wire logic [15:0]       sp_o       // stack pointer
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	logic [1:0] busy_reg; // cycles left in a fetch
	logic taken, side;
	assign taken = ctl_i.fetch && busy_reg == 2'h0;
	assign side = !ctl_i.fetch && busy_reg == 2'h0;
	// count down the fetch window
	always_ff @(posedge mclk_i) begin
		if (reset_i)
			busy_reg <= 2'h0;
		else if (taken)
			busy_reg <= 2'h3;
		else if (busy_reg != 2'h0)
			busy_reg <= busy_reg - 2'h1;
	end
	pc_step_a: assert property (taken && !ctl_i.jump |=> pc_o == $past(pc_o) + 16'h1)
		else $error("pc not advanced");
	fetch_addr_a: assert property (taken |=> addr_o == $past(pc_o))
		else $error("fetch address wrong");
	jump_load_a: assert property (taken && ctl_i.jump |=> pc_o == $past(ctl_i.jump_addr))
		else $error("jump target lost");
	refresh_span_a: assert property (taken |=> !refresh_strobe_o ##1 refresh_strobe_o [*2] ##1 !refresh_strobe_o)
		else $error("refresh window wrong");
	opcode_hold_a: assert property (taken |=> opcode_o == $past(data_i))
		else $error("opcode not latched");
	push_step_a: assert property (side && ctl_i.push |=> sp_o == $past(sp_o) - 16'h1 && addr_o == sp_o)
		else $error("push wrong");
	pop_step_a: assert property (side && ctl_i.pop |=> sp_o == $past(sp_o) + 16'h1 && addr_o == $past(sp_o))
		else $error("pop wrong");
	vector_low_a: assert property (side && ctl_i.vec_go |=> addr_o[7:0] == $past(data_i))
		else $error("vector byte wrong");
	apb_wait_a: assert property (psel_i && penable_i && !$past(penable_i) |-> !pready_o ##1 pready_o)
		else $error("apb wait state wrong");
	fetch_c: cover property (taken ##3 refresh_strobe_o);
	jump_c: cover property (taken && ctl_i.jump);
	push_c: cover property (side && ctl_i.push);
endmodule
bind crf_top crf_properties u_props (.mclk_i, .reset_i, .psel_i, .penable_i, .pready_o, .ctl_i,
	.data_i, .addr_o, .refresh_strobe_o, .opcode_o, .pc_o, .sp_o);
`default_nettype wire

// [crf_top_test.sv]
// file: self-checking bench of the register file
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] %0t got %h want %h", $time, a, e); end end
module crf_top_test;
	logic mclk_i = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, pena = 1'b0, pwr = 1'b0, pready, perr, rfs, pe;
	logic [7:0] paddr = 8'h00, dat, opc;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic [15:0] addr, prd, pc, sp, a1;
	crf_pkg::crf_ctl_t ctl, c = '0;
	crf_pkg::crf_dec_t dcd;
	logic [7:0] acc, flg;
	int fails = 0, check_count = 0;
	always #2.5 mclk_i = ~mclk_i;
	crf_seq_model u_seq (.mclk_i, .ctl_o(ctl), .data_o(dat));
	crf_top u_dut (.mclk_i, .reset_i(rst), .psel_i(psel), .penable_i(pena), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
		.ctl_i(ctl), .data_i(dat), .addr_o(addr), .refresh_strobe_o(rfs), .opcode_o(opc), .dec_o(dcd),
		.pair_rd_o(prd), .acc_o(acc), .flags_o(flg), .pc_o(pc), .sp_o(sp));
	task automatic print_verdict;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one apb transfer, answer taken at the edge that sees pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		pena <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rv = prdata;
		pe = perr;
		psel <= 1'b0;
		pena <= 1'b0;
		if (n >= 20) begin
			fails++;
			print_verdict();
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rv, e)
	endtask
	task automatic send(input logic [7:0] d);
		u_seq.pulse(c, d);
		c = '0;
	endtask
	task automatic fetch(input logic [7:0] op);
		c.fetch = 1'b1;
		send(op);
		repeat (3) @(posedge mclk_i);
	endtask
	task automatic t_reset;
		rdchk(crf_pkg::OFS_PC, 32'h0);
		rdchk(crf_pkg::OFS_PGRF, 32'h0);
		rdchk(crf_pkg::OFS_CTRL, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		`CHK({pe, rv}, 33'h100000000)
	endtask
	task automatic t_refresh;
		apb(1'b1, crf_pkg::OFS_PGRF, 32'h12ff);
		apb(1'b1, crf_pkg::OFS_PC, 32'h0123);
		c.fetch = 1'b1;
		send(8'h00);
		`CHK(addr, 16'h0123)
		@(posedge mclk_i);
		#1;
		`CHK({rfs, addr}, 17'h11280)
		repeat (2) @(posedge mclk_i);
		rdchk(crf_pkg::OFS_PC, 32'h124);
		rdchk(crf_pkg::OFS_PGRF, 32'h1280);
		c.jump = 1'b1;
		c.jump_addr = 16'hbeef;
		fetch(8'h00);
		rdchk(crf_pkg::OFS_PC, 32'hbeef);
	endtask
	task automatic t_address;
		apb(1'b1, crf_pkg::OFS_SP, 32'h0100);
		c.push = 1'b1;
		send(8'h00);
		a1 = addr;
		`CHK(a1, 16'h00ff)
		c.pop = 1'b1;
		send(8'h00);
		`CHK(addr, a1)
		rdchk(crf_pkg::OFS_SP, 32'h0100);
		apb(1'b1, crf_pkg::OFS_IXA, 32'h2000);
		apb(1'b1, crf_pkg::OFS_IXB, 32'h3000);
		{c.idx_go, c.idx_sel, c.disp} = 10'h2fe;
		send(8'h00);
		`CHK(addr, 16'h1ffe)
		{c.idx_go, c.idx_sel, c.disp} = 10'h37f;
		send(8'h00);
		`CHK(addr, 16'h307f)
		c.vec_go = 1'b1;
		send(8'ha5);
		`CHK(addr, 16'h12a5)
	endtask
	task automatic t_swap;
		apb(1'b1, crf_pkg::OFS_AF, 32'h5a81);
		fetch(crf_pkg::OPC_EXAF);
		rdchk(crf_pkg::OFS_AF, 32'h0);
		rdchk(crf_pkg::OFS_CTRL, 32'h2);
		fetch(crf_pkg::OPC_EXAF);
		rdchk(crf_pkg::OFS_AF, 32'h5a81);
		{c.pair_we, c.pair_wd} = 17'h1abcd;
		send(8'h00);
		{c.reg_we, c.reg_wd} = 9'h112;
		send(8'h00);
		@(posedge mclk_i);
		#1;
		`CHK(prd, 16'h12cd)
		fetch(crf_pkg::OPC_EXX);
		{c.pair_we, c.pair_wd} = 17'h11111;
		send(8'h00);
		fetch(crf_pkg::OPC_EXX);
		@(posedge mclk_i);
		#1;
		`CHK(prd, 16'h12cd)
	endtask
	// sequencer alu request, then a decoded alu opcode through fetch
	task automatic t_alu;
		apb(1'b1, crf_pkg::OFS_AF, 32'h0f00);
		c.alu_go = 1'b1;
		c.alu_op = crf_pkg::ALU_ADD;
		c.alu_b = 8'hf1;
		send(8'h00);
		`CHK({acc, flg[crf_pkg::FL_Z], flg[crf_pkg::FL_C]}, 10'h003)
		apb(1'b1, crf_pkg::OFS_AF, 32'h2100);
		c.fetch = 1'b1;
		send(8'h87);
		@(posedge mclk_i);
		#1;
		`CHK({opc, dcd.alu, dcd.op, dcd.src}, 16'h8787)
		repeat (2) @(posedge mclk_i);
		#1;
		`CHK({acc, flg[crf_pkg::FL_Z]}, 9'h084)
	endtask
	initial begin
		repeat (5) @(posedge mclk_i);
		rst <= 1'b0;
		t_reset();
		t_refresh();
		t_address();
		t_swap();
		t_alu();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge mclk_i);
		fails++;
		print_verdict();
	end
endmodule
`default_nettype wire
